// ---- can_mode_ctrl.sv ----
// Transceiver mode control, wake detection and dominant time-outs.
// Assumes an AHB-Lite master, synchronous pins and an analog front end outside.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "can_mode_consts.svh"

// What this block does
// - Reset enters off mode; off mode ignores bus wake activity.
// - Normal mode set by register command, only in chip Normal mode.
// - Normal mode drives bus dominant while transmit input is low.
// - A bit already dominant at enable end is skipped until recessive.
// - Receive output mirrors bus in normal and receive-only: low dominant, high recessive.
// - Receive-only disables driver; allowed in chip Normal and Stop.
// - Wake mode allowed in Stop, Sleep, Restart, Normal; forced in Fail-Safe.
// - Detected wake holds receive output low until a mode change or Stop entry.
// - Wake pattern is dominant, recessive, dominant, each within filter limits.
// - After wake the mode field still reads the wake-capable code.
// - Wake rearms after leaving wake mode and returning, or on the Stop and Fail-Safe events below.
// - Entering Stop or Fail-Safe, or Stop again, rearms wake.
// - Mode toggle clears the bus wake flag.
// - Wake in Normal or Stop pulls interrupt low, records source, keeps mode.
// - Watchdog-on-wake setting enables watchdog on a Stop mode wake.
// - Wake in Sleep goes to Restart then Normal, no interrupt.
// - Transmit dominant too long forces recessive and sets failure flag.
// - Driver resumes once transmit input returns recessive.
// - Bus dominant too long in normal or receive-only sets failure flag.
// - Supply undervoltage in normal or receive-only sets flag; it disables driver, which recovers automatically.
module can_mode_ctrl #(
  parameter int unsigned TX_TIMEOUT_CYC = `N_TX_TIMEOUT,
  parameter int unsigned BUS_TIMEOUT_CYC = `N_BUS_TIMEOUT,
  parameter int unsigned WAKE_MAX_CYC = `N_WAKE_MAX
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic transmit_data_in,
  output logic receive_data_out,
  input wire logic bus_dominant,
  output logic bus_drive_dominant,
  input wire logic transceiver_supply_ok,
  output logic interrupt_n,
  output logic watchdog_enable,
  output can_mode_pkg::chip_mode_e chip_mode,
  output can_mode_pkg::trx_status_s status
);
  import can_mode_pkg::*;

  localparam int unsigned CW = 24;
  localparam logic [CW-1:0] ENABLE_CYC = CW'(`N_ENABLE);
  localparam logic [CW-1:0] WAKE_MIN_CYC = CW'(`N_WAKE_MIN);

  trx_mode_e mode_reg;
  chip_mode_e chip_reg;
  wake_state_e wk_reg;
  logic wd_on_wake_reg, wd_en_reg, wake_flag_reg, armed_reg, int_reg;
  logic fail_reg, uv_reg, enabled_reg, skip_reg, tx_to_reg, restart_step_reg;
  logic ap_valid_reg, ap_write_reg, drive_reg, rx_reg, wake_hit, wr_ctrl;
  logic [31:0] wake_src_reg;
  logic [31:0] ap_addr_reg;
  logic [CW-1:0] wk_cnt_reg, en_cnt_reg, tx_cnt_reg, bus_cnt_reg;

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    return (&v) ? v : v + CW'(1);
  endfunction

  function automatic logic mode_ok(input trx_mode_e m, input chip_mode_e c);
    case (m)
      TRX_OFF: mode_ok = 1'b1;
      TRX_NORMAL: mode_ok = (c == CHIP_NORMAL);
      TRX_RXONLY: mode_ok = (c == CHIP_NORMAL) || (c == CHIP_STOP);
      TRX_WAKE: mode_ok = (c != CHIP_FAILSAFE);
      default: mode_ok = 1'b0;
    endcase
  endfunction

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_ctrl = ap_valid_reg && ap_write_reg && (ap_addr_reg == `REG_CTRL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 32'h0000_0000;
    end else if (hready) begin
      ap_valid_reg <= hsel && htrans[1];
      ap_write_reg <= hwrite;
      ap_addr_reg <= {haddr[31:2], 2'b00};
    end
  end

  always_comb begin
    hrdata = 32'h0000_0000;
    if (ap_valid_reg && !ap_write_reg) begin
      case (ap_addr_reg)
        `REG_CTRL: hrdata = {22'h0, 1'b0, wd_on_wake_reg, 1'b0, chip_reg, 2'b00, mode_reg};
        `REG_STAT: hrdata = {27'h0, wd_en_reg, fail_reg, uv_reg, wake_flag_reg, drive_reg};
        `REG_WAKE: hrdata = wake_src_reg;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Wake hit only when armed in wake mode
  // off mode ignores wake
  assign wake_hit = (wk_reg == WK_DOM2) && !bus_dominant && (wk_cnt_reg > WAKE_MIN_CYC)
    && (wk_cnt_reg < CW'(WAKE_MAX_CYC)) && (mode_reg == TRX_WAKE) && armed_reg;

  // Transceiver mode field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= TRX_OFF;
      wd_on_wake_reg <= 1'b0;
    end else if (wr_ctrl) begin
      wd_on_wake_reg <= hwdata[`CTRL_WDWK_BIT];
      if (mode_ok(trx_mode_e'(hwdata[`CTRL_MODE_LSB +: 2]), chip_reg)) begin
        mode_reg <= trx_mode_e'(hwdata[`CTRL_MODE_LSB +: 2]);
      end
    end else if (chip_reg == CHIP_FAILSAFE) begin
      mode_reg <= TRX_WAKE;
    end else if (mode_reg == TRX_NORMAL && chip_reg != CHIP_NORMAL) begin
      mode_reg <= TRX_WAKE;
    end
  end

  // Chip mode sequencing on bus wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_reg <= CHIP_NORMAL;
      restart_step_reg <= 1'b0;
    end else if (wake_hit && (chip_reg == CHIP_SLEEP || chip_reg == CHIP_FAILSAFE)) begin
      chip_reg <= CHIP_RESTART;
      restart_step_reg <= 1'b1;
    end else if (restart_step_reg) begin
      chip_reg <= CHIP_NORMAL;
      restart_step_reg <= 1'b0;
    end else if (wr_ctrl) begin
      chip_reg <= chip_mode_e'(hwdata[`CTRL_CHIP_LSB +: 3]);
    end
  end

  // Wake flag, arming, source record and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_flag_reg <= 1'b0;
      armed_reg <= 1'b1;
      int_reg <= 1'b1;
      wake_src_reg <= 32'h0000_0000;
      wd_en_reg <= 1'b0;
    end else begin
      if (wake_hit) begin
        wake_flag_reg <= 1'b1;
        armed_reg <= 1'b0;
        wake_src_reg <= 32'h0000_0001;
        if (chip_reg == CHIP_NORMAL || chip_reg == CHIP_STOP) begin
          int_reg <= 1'b0;
        end
        if (chip_reg == CHIP_STOP && wd_on_wake_reg) begin
          wd_en_reg <= 1'b1;
        end
      end else if (wr_ctrl) begin
        if (hwdata[`CTRL_MODE_LSB +: 2] != TRX_WAKE) begin
          wake_flag_reg <= 1'b0;
          armed_reg <= 1'b1;
        end
        if (hwdata[`CTRL_CHIP_LSB +: 3] == CHIP_STOP || hwdata[`CTRL_STOPCMD_BIT]) begin
          wake_flag_reg <= 1'b0;
          armed_reg <= 1'b1;
        end
      end else if (chip_reg == CHIP_FAILSAFE && !armed_reg) begin
        armed_reg <= 1'b1;
      end
      if (ap_valid_reg && !ap_write_reg && ap_addr_reg == `REG_WAKE && !wake_hit) begin
        wake_src_reg <= 32'h0000_0000;
        int_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wk_reg <= WK_IDLE;
      wk_cnt_reg <= '0;
    end else if (mode_reg != TRX_WAKE || !armed_reg) begin
      wk_reg <= WK_IDLE;
      wk_cnt_reg <= '0;
    end else begin
      case (wk_reg)
        WK_IDLE: begin
          wk_cnt_reg <= '0;
          if (bus_dominant) begin
            wk_reg <= WK_DOM1;
          end
        end
        WK_DOM1, WK_REC, WK_DOM2: begin
          if (bus_dominant == (wk_reg != WK_REC)) begin
            wk_cnt_reg <= sat_inc(wk_cnt_reg);
          end else if (wk_cnt_reg > WAKE_MIN_CYC && wk_cnt_reg < CW'(WAKE_MAX_CYC)) begin
            wk_reg <= (wk_reg == WK_DOM1) ? WK_REC : (wk_reg == WK_REC) ? WK_DOM2 : WK_IDLE;
            wk_cnt_reg <= '0;
          end else begin
            wk_reg <= bus_dominant ? WK_DOM1 : WK_IDLE;
            wk_cnt_reg <= '0;
          end
        end
        default: wk_reg <= WK_IDLE;
      endcase
    end
  end

  // enable delay and skipped first bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_cnt_reg <= '0;
      enabled_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else if (mode_reg != TRX_NORMAL) begin
      en_cnt_reg <= '0;
      enabled_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else if (!enabled_reg) begin
      en_cnt_reg <= sat_inc(en_cnt_reg);
      if (en_cnt_reg >= ENABLE_CYC - CW'(1)) begin
        enabled_reg <= 1'b1;
        skip_reg <= !transmit_data_in;
      end
    end else if (transmit_data_in) begin
      skip_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cnt_reg <= '0;
      tx_to_reg <= 1'b0;
    end else if (mode_reg != TRX_NORMAL || transmit_data_in) begin
      tx_cnt_reg <= '0;
      tx_to_reg <= 1'b0;
    end else begin
      tx_cnt_reg <= sat_inc(tx_cnt_reg);
      if (tx_cnt_reg >= CW'(TX_TIMEOUT_CYC)) begin
        tx_to_reg <= 1'b1;
      end
    end
  end

  // Failure and undervoltage flags, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_cnt_reg <= '0;
      fail_reg <= 1'b0;
      uv_reg <= 1'b0;
    end else begin
      if ((mode_reg == TRX_NORMAL || mode_reg == TRX_RXONLY) && bus_dominant) begin
        bus_cnt_reg <= sat_inc(bus_cnt_reg);
      end else begin
        bus_cnt_reg <= '0;
      end
      if (tx_cnt_reg >= CW'(TX_TIMEOUT_CYC) || bus_cnt_reg >= CW'(BUS_TIMEOUT_CYC)) begin
        fail_reg <= 1'b1;
      end else if (ap_valid_reg && !ap_write_reg && ap_addr_reg == `REG_STAT) begin
        fail_reg <= 1'b0;
      end
      // supply tracked only in active modes
      if ((mode_reg == TRX_NORMAL || mode_reg == TRX_RXONLY) && !transceiver_supply_ok) begin
        uv_reg <= 1'b1;
      end else if (ap_valid_reg && !ap_write_reg && ap_addr_reg == `REG_STAT) begin
        uv_reg <= 1'b0;
      end
    end
  end

  // early dominant absorbed by enable gating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= (mode_reg == TRX_NORMAL) && enabled_reg && !skip_reg && !tx_to_reg
        && (tx_cnt_reg < CW'(TX_TIMEOUT_CYC)) && transceiver_supply_ok && !transmit_data_in;
    end
  end

  // receive level; held low after wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_reg <= 1'b1;
    end else if (mode_reg == TRX_WAKE) begin
      rx_reg <= !(wake_flag_reg || wake_hit);
    end else if (mode_reg == TRX_OFF) begin
      rx_reg <= 1'b1;
    end else begin
      rx_reg <= !bus_dominant;
    end
  end

  assign bus_drive_dominant = drive_reg;
  assign receive_data_out = rx_reg;
  assign interrupt_n = int_reg;
  assign watchdog_enable = wd_en_reg;
  assign chip_mode = chip_reg;
  assign status = '{fail_flag: fail_reg, uv_flag: uv_reg, wake_flag: wake_flag_reg,
    driver_on: drive_reg};

  a_tx_timeout_quiet:
    assert property (@(posedge hclk) disable iff (!hresetn)
      tx_to_reg |-> !bus_drive_dominant) else $error("driver active after time-out");
  a_normal_mode_gate:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_reg == TRX_NORMAL) |-> (chip_reg == CHIP_NORMAL) || $changed(chip_reg))
    else $error("normal mode outside chip Normal");
  a_wake_holds_rx:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (wake_flag_reg && mode_reg == TRX_WAKE && $stable(mode_reg)) |=> !receive_data_out)
    else $error("receive output released while woken");
  a_off_no_wake:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_reg == TRX_OFF) |=> !$rose(wake_flag_reg)) else $error("wake seen in off mode");
  a_failsafe_wake:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (chip_reg == CHIP_FAILSAFE && !wr_ctrl) |=> mode_reg == TRX_WAKE)
    else $error("fail-safe did not force wake mode");
  a_sleep_restart:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (wake_hit && chip_reg == CHIP_SLEEP) |=> chip_reg == CHIP_RESTART ##1
      chip_reg == CHIP_NORMAL) else $error("sleep wake sequence wrong");
  a_stop_wake_int:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (wake_hit && chip_reg == CHIP_STOP) |=> !interrupt_n && chip_reg == CHIP_STOP)
    else $error("stop wake interrupt missing");
  a_rxonly_no_drive:
    assert property (@(posedge hclk) disable iff (!hresetn)
      (mode_reg == TRX_RXONLY) [*2] |-> !bus_drive_dominant)
    else $error("driver active in receive-only");
endmodule

// ---- can_mode_consts.svh ----
// Constants for the transceiver mode control block.
// Assumes inclusion by the design, the host model and the bench.
`ifndef CAN_MODE_CONSTS_SVH
`define CAN_MODE_CONSTS_SVH
`define CLK_FREQ_HZ 50000000
`define CLK_PERIOD_NS 20
`define T_ENABLE_NS 10000
`define T_WAKE_MIN_NS 500
`define T_WAKE_MAX_NS 1800000
`define T_TX_TIMEOUT_NS 2700000
`define T_BUS_TIMEOUT_NS 2700000
`define N_ENABLE ((`T_ENABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define N_WAKE_MIN ((`T_WAKE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define N_WAKE_MAX (`T_WAKE_MAX_NS / `CLK_PERIOD_NS)
`define N_TX_TIMEOUT (`T_TX_TIMEOUT_NS / `CLK_PERIOD_NS)
`define N_BUS_TIMEOUT (`T_BUS_TIMEOUT_NS / `CLK_PERIOD_NS)
`define REG_CTRL 32'h0000_0000
`define REG_STAT 32'h0000_0004
`define REG_WAKE 32'h0000_0008
`define CTRL_MODE_LSB 0
`define CTRL_CHIP_LSB 4
`define CTRL_WDWK_BIT 8
`define CTRL_STOPCMD_BIT 9
`define CTRL_RESET 32'h0000_0000
`endif

// ---- can_mode_pkg.sv ----
// Types for the transceiver mode control block.
// Assumes can_mode_consts.svh sits in the same folder.
package can_mode_pkg;
  typedef enum logic [1:0] {
    TRX_OFF = 2'b00,
    TRX_WAKE = 2'b01,
    TRX_NORMAL = 2'b10,
    TRX_RXONLY = 2'b11
  } trx_mode_e;
  typedef enum logic [2:0] {
    CHIP_NORMAL = 3'b000,
    CHIP_STOP = 3'b001,
    CHIP_SLEEP = 3'b010,
    CHIP_RESTART = 3'b011,
    CHIP_FAILSAFE = 3'b100
  } chip_mode_e;
  typedef enum logic [1:0] {
    WK_IDLE = 2'b00,
    WK_DOM1 = 2'b01,
    WK_REC = 2'b10,
    WK_DOM2 = 2'b11
  } wake_state_e;
  typedef struct packed {
    logic fail_flag;
    logic uv_flag;
    logic wake_flag;
    logic driver_on;
  } trx_status_s;
endpackage

// ---- can_host_model.sv ----
// Host protocol controller model driving the transmit line.
// Assumes the bench raises enabled when it commands normal mode.
`timescale 1ns/10ps
`include "can_mode_consts.svh"
module can_host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enabled,
  input wire logic want_dominant,
  input wire logic rush,
  output logic transmit_data_in
);
  int unsigned en_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_cnt <= 0;
    end else if (!enabled) begin
      en_cnt <= 0;
    end else if (en_cnt < `N_ENABLE + 2) begin
      en_cnt <= en_cnt + 1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transmit_data_in <= 1'b1;
    end else begin
      transmit_data_in <= !(want_dominant && (rush || en_cnt > `N_ENABLE));
    end
  end
endmodule

// ---- test_can_mode_ctrl.sv ----
// Bench for the transceiver mode control block.
// Assumes the host model file and the design compile first.
`timescale 1ns/10ps
`include "can_mode_consts.svh"
module test_can_mode_ctrl;
  import can_mode_pkg::*;
  localparam int unsigned TO = 200;
  logic hclk, hresetn, hsel, hwrite, ext_dom, supply_ok;
  logic enabled, want_dom, rush;
  int restart_cnt = 0;
  int restart_mark;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, tx, rx, drive, int_n, wd;
  chip_mode_e chip;
  trx_status_s status;
  wire bus_dom = ext_dom | drive;
  int mismatches, check_count;
  can_mode_ctrl #(.TX_TIMEOUT_CYC(TO), .BUS_TIMEOUT_CYC(TO), .WAKE_MAX_CYC(TO))
  can_mode_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .transmit_data_in(tx), .receive_data_out(rx), .bus_dominant(bus_dom),
    .bus_drive_dominant(drive), .transceiver_supply_ok(supply_ok),
    .interrupt_n(int_n), .watchdog_enable(wd), .chip_mode(chip), .status(status)
  );
  can_host_model can_host_model_inst (
    .hclk(hclk), .hresetn(hresetn), .enabled(enabled), .want_dominant(want_dom),
    .rush(rush), .transmit_data_in(tx)
  );
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (chip === CHIP_RESTART) begin
      restart_cnt <= restart_cnt + 1;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    $display("[ERR] %0t wait limit", $time);
    tally_and_finish();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic phase(output logic [31:0] d);
    int n;
    logic r;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      d = hrdata;
      r = hreadyout;
    end while (r !== 1'b1 && n < 50);
    if (r !== 1'b1) begin
      give_up();
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wv);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    phase(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wv;
    phase(rd);
  endtask
  task automatic ctl(input logic [1:0] m, input logic [2:0] c, input logic [1:0] x);
    xfer(1'b1, `REG_CTRL, {22'h0, x, 1'b0, c, 2'b00, m});
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & mask, e);
  endtask
  task automatic wup(input int d);
    ext_dom <= 1'b1;
    cyc(d);
    ext_dom <= 1'b0;
    cyc(d);
    ext_dom <= 1'b1;
    cyc(d);
    ext_dom <= 1'b0;
    cyc(30);
  endtask
  task automatic wait_normal();
    int n;
    n = 0;
    while (chip !== CHIP_NORMAL && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 1000) begin
      give_up();
    end
  endtask
  initial begin
    {hresetn, hsel, hwrite, ext_dom, supply_ok, enabled, want_dom, rush} = 8'h0;
    {haddr, hwdata, htrans, hsize} = 69'h0;
    mismatches = 0;
    check_count = 0;
    cyc(8);
    hresetn <= 1'b1;
    cyc(1);
    chk({rx, drive, int_n, wd, chip}, {4'ha, CHIP_NORMAL});
    rdchk(`REG_CTRL, 32'h3, 32'h0);
    wup(50);
    chk(int_n, 1'b1);
    rdchk(`REG_WAKE, 32'h1, 32'h0);
    chk({hresp, hreadyout}, 2'b01);
    supply_ok <= 1'b1;
    ctl(TRX_NORMAL, CHIP_NORMAL, 2'b00);
    enabled <= 1'b1;
    want_dom <= 1'b1;
    cyc(520);
    chk({drive, rx, status.driver_on}, 3'b101);
    rdchk(`REG_CTRL, 32'h3, 32'h2);
    cyc(TO);
    chk({drive, status.fail_flag}, 2'b01);
    rdchk(`REG_CTRL, 32'h3, 32'h2);
    want_dom <= 1'b0;
    cyc(5);
    chk(rx, 1'b1);
    want_dom <= 1'b1;
    cyc(5);
    chk(drive, 1'b1);
    want_dom <= 1'b0;
    rdchk(`REG_STAT, 32'h8, 32'h8);
    ctl(TRX_OFF, CHIP_NORMAL, 2'b00);
    enabled <= 1'b0;
    rush <= 1'b1;
    ctl(TRX_NORMAL, CHIP_NORMAL, 2'b00);
    cyc(400);
    want_dom <= 1'b1;
    cyc(130);
    chk(drive, 1'b0);
    want_dom <= 1'b0;
    cyc(3);
    want_dom <= 1'b1;
    cyc(3);
    chk(drive, 1'b1);
    want_dom <= 1'b0;
    rush <= 1'b0;
    ctl(TRX_OFF, CHIP_STOP, 2'b00);
    ctl(TRX_NORMAL, CHIP_STOP, 2'b00);
    rdchk(`REG_CTRL, 32'h3, 32'h0);
    ctl(TRX_RXONLY, CHIP_STOP, 2'b00);
    rdchk(`REG_CTRL, 32'h3, 32'h3);
    rdchk(`REG_STAT, 32'h8, 32'h0);
    ext_dom <= 1'b1;
    want_dom <= 1'b1;
    rush <= 1'b1;
    cyc(5);
    chk({drive, rx, chip}, {2'b00, CHIP_STOP});
    cyc(TO + 10);
    chk(status.fail_flag, 1'b1);
    rdchk(`REG_CTRL, 32'h3, 32'h3);
    {ext_dom, want_dom, rush} <= 3'b000;
    ctl(TRX_WAKE, CHIP_NORMAL, 2'b00);
    supply_ok <= 1'b0;
    wup(50);
    chk({int_n, rx, status.wake_flag, chip}, {3'b001, CHIP_NORMAL});
    rdchk(`REG_CTRL, 32'h3, 32'h1);
    rdchk(`REG_WAKE, 32'h1, 32'h1);
    cyc(1);
    chk({int_n, rx}, 2'b10);
    wup(50);
    chk(int_n, 1'b1);
    ctl(TRX_OFF, CHIP_NORMAL, 2'b00);
    cyc(2);
    chk({rx, status.wake_flag}, 2'b10);
    ctl(TRX_WAKE, CHIP_NORMAL, 2'b00);
    wup(10);
    chk(int_n, 1'b1);
    wup(TO + 30);
    chk(int_n, 1'b1);
    wup(50);
    chk(int_n, 1'b0);
    rdchk(`REG_WAKE, 32'h1, 32'h1);
    ctl(TRX_WAKE, CHIP_STOP, 2'b01);
    chk(wd, 1'b0);
    wup(50);
    chk({int_n, wd, chip}, {2'b01, CHIP_STOP});
    rdchk(`REG_WAKE, 32'h1, 32'h1);
    wup(50);
    chk(int_n, 1'b1);
    ctl(TRX_WAKE, CHIP_STOP, 2'b10);
    wup(50);
    chk(int_n, 1'b0);
    rdchk(`REG_WAKE, 32'h1, 32'h1);
    ctl(TRX_OFF, CHIP_STOP, 2'b00);
    ctl(TRX_WAKE, CHIP_STOP, 2'b00);
    ctl(TRX_WAKE, CHIP_SLEEP, 2'b00);
    cyc(1);
    chk(chip, CHIP_SLEEP);
    wup(50);
    wait_normal();
    chk({int_n, rx, restart_cnt > 0}, 3'b101);
    rdchk(`REG_WAKE, 32'h1, 32'h1);
    restart_mark = restart_cnt;
    ctl(TRX_OFF, CHIP_FAILSAFE, 2'b00);
    rdchk(`REG_CTRL, 32'h3, 32'h1);
    wup(50);
    wait_normal();
    chk({int_n, rx, restart_cnt > restart_mark}, 3'b101);
    supply_ok <= 1'b1;
    ctl(TRX_NORMAL, CHIP_NORMAL, 2'b00);
    enabled <= 1'b1;
    want_dom <= 1'b1;
    cyc(520);
    supply_ok <= 1'b0;
    cyc(5);
    chk({drive, status.uv_flag}, 2'b01);
    supply_ok <= 1'b1;
    cyc(5);
    chk(drive, 1'b1);
    rdchk(`REG_CTRL, 32'h3, 32'h2);
    tally_and_finish();
  end
endmodule
